// ==== crt_vt_pkg.sv ====
// constants shared by the vertical timing and address shaping logic
package crt_vt_pkg;

    // ************************************************************
    // register indexes on the crt data port
    // ************************************************************
    localparam logic [7:0] IDX_VBLANK_START_LOW = 8'h15;
    localparam logic [7:0] IDX_VBLANK_END = 8'h16;
    localparam logic [7:0] IDX_CRT_MODE_CONTROL = 8'h17;
    localparam logic [7:0] IDX_SPLIT_LINE_COMPARE_LOW = 8'h18;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_VBLANK_START_LOW = 8'h00;
    localparam logic [7:0] RST_VBLANK_END = 8'h00;
    localparam logic [7:0] RST_CRT_MODE_CONTROL = 8'h00;
    localparam logic [7:0] RST_SPLIT_LINE_COMPARE_LOW = 8'h00;

    // ************************************************************
    // field positions and masks
    // ************************************************************
    localparam logic [7:0] MASK_BLANK_END_VALUE = 8'h7F;
    localparam logic [7:0] MASK_MODE_CONTROL = 8'hEF;
    localparam int POS_TIMING_ENABLE = 7;
    localparam int POS_WORD_BYTE = 6;
    localparam int POS_WRAP_SELECT = 5;
    localparam int POS_COUNT_BY_TWO = 3;
    localparam int POS_RETRACE_CLOCK_SELECT = 2;
    localparam int POS_ROW_SCAN_SELECT = 1;
    localparam int POS_COMPAT_MUX_SELECT = 0;
    localparam int POS_BLANK_START_BIT8 = 3;
    localparam int POS_SPLIT_LINE_BIT8 = 4;
    localparam int POS_SPLIT_LINE_BIT9 = 6;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int LINE_W = 10;
    localparam int ADDR_W = 16;

endpackage : crt_vt_pkg

// ==== crt_line_counter.sv ====
// vertical scan line counter clocked from horizontal retrace edges
`timescale 1ns/1ps

module crt_line_counter
    import crt_vt_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // control
    input wire logic timingEnable,
    input wire logic retraceClockSelect,
    input wire logic hRetrace,
    input wire logic [LINE_W-1:0] verticalTotal,
    // state
    output logic [LINE_W-1:0] lineCount,
    output logic lineStep
);

    typedef struct packed {
        logic retracePrev;
        logic halfPhase;
        logic [LINE_W-1:0] count;
        logic step;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic retraceEdge;

    assign retraceEdge = hRetrace && !st_r.retracePrev;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.retracePrev = hRetrace;
        st_nxt.step = 1'b0;
        if (!timingEnable)
        begin
            st_nxt.count = '0;
            st_nxt.halfPhase = 1'b0;
        end
        else if (retraceEdge)
        begin
            st_nxt.halfPhase = !st_r.halfPhase;
            if (!retraceClockSelect || st_r.halfPhase)
            begin
                st_nxt.step = 1'b1;
                if (st_r.count == verticalTotal)
                    st_nxt.count = '0;
                else
                    st_nxt.count = st_r.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign lineCount = st_r.count;
    assign lineStep = st_r.step;

    AST_FULL_RATE_STEP: assert property (@(posedge clock) disable iff (reset)
        timingEnable && retraceEdge && !retraceClockSelect |=> lineStep)
        else $error("line counter missed a retrace edge");

    AST_HALF_RATE_SKIP: assert property (@(posedge clock) disable iff (reset)
        timingEnable && retraceEdge && retraceClockSelect && !st_r.halfPhase |=> !lineStep)
        else $error("line counter stepped on a skipped edge");

    AST_WRAP_AT_TOTAL: assert property (@(posedge clock) disable iff (reset)
        lineStep && $past(lineCount) == $past(verticalTotal) && $past(timingEnable) |-> lineCount == '0)
        else $error("line counter did not wrap at vertical total");

endmodule : crt_line_counter

// ==== crt_vertical_timing_addr_ctrl.sv ====
// vertical blanking, mode control and display refresh address shaping
`timescale 1ns/1ps

module crt_vertical_timing_addr_ctrl
    import crt_vt_pkg::*;
(
    // clock and reset, clock is the character clock
    input wire logic clock,
    input wire logic reset,
    // indexed register port
    input wire logic [7:0] regIndex,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // values held in neighbouring crt registers
    input wire logic [7:0] overflowReg,
    input wire logic [7:0] maxScanLineReg,
    input wire logic [LINE_W-1:0] verticalTotal,
    input wire logic [ADDR_W-1:0] startAddress,
    // raw timing from the horizontal side
    input wire logic hRetrace,
    input wire logic displayActive,
    input wire logic [4:0] rowScan,
    // timing outputs
    output logic hRetraceOut,
    output logic vBlankOut,
    output logic displayEnableOut,
    output logic [LINE_W-1:0] lineCount,
    // display memory address
    output logic [ADDR_W-1:0] memAddr
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [7:0] vblankStartLow;
        logic [7:0] vblankEnd;
        logic [7:0] modeControl;
        logic [7:0] splitLineLow;
        logic [7:0] rdData;
        logic vBlank;
        logic hRetraceOut;
        logic displayEnable;
        logic countPhase;
        logic [ADDR_W-1:0] addrCnt;
        logic [ADDR_W-1:0] memAddr;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic timingEnable;
    logic wordByte;
    logic wrapSelect;
    logic countByTwo;
    logic retraceClockSelect;
    logic rowScanSelect;
    logic compatMuxSelect;
    logic [8:0] blankStartValue;
    logic [6:0] blankEndValue;
    logic [LINE_W-1:0] splitLineTarget;
    logic lineStep;
    logic startHit;
    logic endHit;
    logic splitHit;
    logic frameStart;
    logic addrAdvance;
    logic [ADDR_W-1:0] shapedAddr;

    assign timingEnable = st_r.modeControl[POS_TIMING_ENABLE];
    assign wordByte = st_r.modeControl[POS_WORD_BYTE];
    assign wrapSelect = st_r.modeControl[POS_WRAP_SELECT];
    assign countByTwo = st_r.modeControl[POS_COUNT_BY_TWO];
    assign retraceClockSelect = st_r.modeControl[POS_RETRACE_CLOCK_SELECT];
    assign rowScanSelect = st_r.modeControl[POS_ROW_SCAN_SELECT];
    assign compatMuxSelect = st_r.modeControl[POS_COMPAT_MUX_SELECT];

    assign blankStartValue = {overflowReg[POS_BLANK_START_BIT8], st_r.vblankStartLow};
    assign blankEndValue = st_r.vblankEnd[6:0];
    assign splitLineTarget = {maxScanLineReg[POS_SPLIT_LINE_BIT9], overflowReg[POS_SPLIT_LINE_BIT8],
        st_r.splitLineLow};

    // ************************************************************
    // vertical line counter
    // ************************************************************
    // ten-bit total, doubled span via half rate
    crt_line_counter lineCounter
    (
        .clock(clock),
        .reset(reset),
        .timingEnable(timingEnable),
        .retraceClockSelect(retraceClockSelect),
        .hRetrace(hRetrace),
        .verticalTotal(verticalTotal),
        .lineCount(lineCount),
        .lineStep(lineStep)
    );

    // matches act once, on the cycle the count has just moved
    assign startHit = lineStep && (lineCount[8:0] == blankStartValue);
    assign endHit = lineStep && (lineCount[6:0] == blankEndValue);
    assign splitHit = lineStep && (lineCount == splitLineTarget);
    assign frameStart = lineStep && (lineCount == '0);
    // every clock or every second clock
    // the halving phase restarts at each frame and split so both screens start on a whole word
    assign addrAdvance = displayActive && (!countByTwo || st_r.countPhase);

    // ************************************************************
    // address shaping
    // ************************************************************
    always_comb
    begin
        shapedAddr = st_r.addrCnt;
        // word mode shift and wrap bit
        if (!wordByte)
            shapedAddr = {st_r.addrCnt[ADDR_W-2:0], wrapSelect ? st_r.addrCnt[15] : st_r.addrCnt[13]};
        if (!rowScanSelect)
            shapedAddr[14] = rowScan[1];
        if (!compatMuxSelect)
            shapedAddr[13] = rowScan[0];
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        st_nxt = st_r;
        if (regWrite)
        begin
            unique case (regIndex)
                IDX_VBLANK_START_LOW: st_nxt.vblankStartLow = regWrData;
                IDX_VBLANK_END: st_nxt.vblankEnd = regWrData & MASK_BLANK_END_VALUE;
                IDX_CRT_MODE_CONTROL: st_nxt.modeControl = regWrData & MASK_MODE_CONTROL;
                IDX_SPLIT_LINE_COMPARE_LOW: st_nxt.splitLineLow = regWrData;
                default: ;
            endcase
        end
        if (regRead)
        begin
            unique case (regIndex)
                IDX_VBLANK_START_LOW: st_nxt.rdData = st_r.vblankStartLow;
                IDX_VBLANK_END: st_nxt.rdData = st_r.vblankEnd;
                IDX_CRT_MODE_CONTROL: st_nxt.rdData = st_r.modeControl;
                IDX_SPLIT_LINE_COMPARE_LOW: st_nxt.rdData = st_r.splitLineLow;
                default: st_nxt.rdData = 8'h00;
            endcase
        end
        // timing outputs held off when disabled
        if (!timingEnable)
        begin
            st_nxt.vBlank = 1'b0;
            st_nxt.hRetraceOut = 1'b0;
            st_nxt.displayEnable = 1'b0;
        end
        else
        begin
            // start wins when both compares hit the same line
            if (startHit)
                st_nxt.vBlank = 1'b1;
            else if (endHit)
                st_nxt.vBlank = 1'b0;
            st_nxt.hRetraceOut = hRetrace;
            st_nxt.displayEnable = displayActive && !st_r.vBlank;
        end
        if (displayActive)
            st_nxt.countPhase = !st_r.countPhase;
        if (splitHit)
        begin
            st_nxt.addrCnt = '0;
            st_nxt.countPhase = 1'b0;
        end
        else if (frameStart)
        begin
            st_nxt.addrCnt = startAddress;
            st_nxt.countPhase = 1'b0;
        end
        else if (addrAdvance)
            st_nxt.addrCnt = st_r.addrCnt + 1'b1;
        st_nxt.memAddr = shapedAddr;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            st_r <= '0;
            st_r.vblankStartLow <= RST_VBLANK_START_LOW;
            st_r.vblankEnd <= RST_VBLANK_END;
            st_r.modeControl <= RST_CRT_MODE_CONTROL;
            st_r.splitLineLow <= RST_SPLIT_LINE_COMPARE_LOW;
        end
        else
            st_r <= st_nxt;
    end

    assign regRdData = st_r.rdData;
    assign hRetraceOut = st_r.hRetraceOut;
    assign vBlankOut = st_r.vBlank;
    assign displayEnableOut = st_r.displayEnable;
    assign memAddr = st_r.memAddr;

    // ************************************************************
    // checks
    // ************************************************************
    // blank start line
    AST_BLANK_START: assert property (@(posedge clock) disable iff (reset)
        timingEnable && lineStep && lineCount[8:0] == {overflowReg[POS_BLANK_START_BIT8], st_r.vblankStartLow}
        && !(regWrite && regIndex == IDX_CRT_MODE_CONTROL) |=> vBlankOut)
        else $error("blanking did not start at blank start line");

    AST_BLANK_END: assert property (@(posedge clock) disable iff (reset)
        timingEnable && endHit && !startHit |=> !vBlankOut)
        else $error("blanking did not end at blank end line");

    AST_TIMING_OFF: assert property (@(posedge clock) disable iff (reset)
        !timingEnable |=> !vBlankOut && !hRetraceOut && !displayEnableOut)
        else $error("timing output active while disabled");

    AST_LINE_HELD_OFF: assert property (@(posedge clock) disable iff (reset)
        !timingEnable |=> lineCount == '0)
        else $error("line count moved while timing disabled");

    AST_RETRACE_PASS: assert property (@(posedge clock) disable iff (reset)
        timingEnable |=> hRetraceOut == $past(hRetrace))
        else $error("retrace output does not follow retrace input");

    AST_DISPLAY_ENABLE: assert property (@(posedge clock) disable iff (reset)
        timingEnable |=> displayEnableOut == ($past(displayActive) && !$past(vBlankOut)))
        else $error("display enable wrong while timing enabled");

    AST_WORD_SHIFT: assert property (@(posedge clock) disable iff (reset)
        !wordByte |=> memAddr[12:1] == $past(st_r.addrCnt[11:0]))
        else $error("word mode address not shifted");

    AST_BYTE_PASS: assert property (@(posedge clock) disable iff (reset)
        wordByte |=> memAddr[12:0] == $past(st_r.addrCnt[12:0]))
        else $error("byte mode address altered");

    AST_WRAP_BIT: assert property (@(posedge clock) disable iff (reset)
        !wordByte |=> memAddr[0] == ($past(wrapSelect) ? $past(st_r.addrCnt[15]) : $past(st_r.addrCnt[13])))
        else $error("wrong wrap bit on address bit zero");

    AST_COUNT_RATE: assert property (@(posedge clock) disable iff (reset)
        countByTwo && displayActive && !lineStep ##1 countByTwo && displayActive && !lineStep
        |=> st_r.addrCnt == $past(st_r.addrCnt, 2) + 16'h0001)
        else $error("count by two rate wrong");

    AST_COUNT_FULL: assert property (@(posedge clock) disable iff (reset)
        !countByTwo && displayActive && !lineStep |=> st_r.addrCnt == $past(st_r.addrCnt) + 16'h0001)
        else $error("address counter missed a character clock");

    AST_ROW_SCAN_14: assert property (@(posedge clock) disable iff (reset)
        !rowScanSelect |=> memAddr[14] == $past(rowScan[1]))
        else $error("address bit 14 not from row scan");

    AST_COMPAT_13: assert property (@(posedge clock) disable iff (reset)
        !compatMuxSelect |=> memAddr[13] == $past(rowScan[0]))
        else $error("address bit 13 not from row scan");

    AST_SPLIT_CLEAR: assert property (@(posedge clock) disable iff (reset)
        lineStep && lineCount == {maxScanLineReg[POS_SPLIT_LINE_BIT9], overflowReg[POS_SPLIT_LINE_BIT8],
        st_r.splitLineLow}
        |=> st_r.addrCnt == '0)
        else $error("split line did not clear address counter");

endmodule : crt_vertical_timing_addr_ctrl

// ==== crt_far_side_model.sv ====
// far-side model: monitor that counts horizontal sync pulses it receives
`timescale 1ns/1ps

module crt_far_side_model
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // sync from the block
    input wire logic hSync,
    // observation
    output int syncCount
);
    logic hSyncPrev;

    // a monitor locks on edges, so only rising edges count
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            hSyncPrev <= 1'b0;
            syncCount <= 0;
        end
        else
        begin
            hSyncPrev <= hSync;
            if (hSync && !hSyncPrev)
                syncCount <= syncCount + 1;
        end
    end
endmodule : crt_far_side_model

// ==== crt_vertical_timing_addr_ctrl_tb_top.sv ====
// self-checking testbench for vertical timing and address shaping
`timescale 1ns/1ps

module crt_vertical_timing_addr_ctrl_tb_top
    import crt_vt_pkg::*;
;
    localparam logic [15:0] START = 16'hA5C3;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic regWrite = 1'b0, regRead = 1'b0, hRetrace = 1'b0, displayActive = 1'b0;
    logic [7:0] regIndex = 8'h00, regWrData = 8'h00, overflowReg = 8'h00, maxScanLineReg = 8'h00;
    logic [LINE_W-1:0] verticalTotal = 10'h3FF;
    logic [ADDR_W-1:0] startAddress = START;
    logic [4:0] rowScan = 5'h00;
    logic [7:0] regRdData;
    logic hRetraceOut, vBlankOut, displayEnableOut;
    logic [LINE_W-1:0] lineCount;
    logic [ADDR_W-1:0] memAddr;
    int num_errors = 0, comparisons = 0, cycles = 0, syncCount;

    crt_vertical_timing_addr_ctrl dut(.clock(clock), .reset(reset), .regIndex(regIndex),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .overflowReg(overflowReg), .maxScanLineReg(maxScanLineReg), .verticalTotal(verticalTotal),
        .startAddress(startAddress), .hRetrace(hRetrace), .displayActive(displayActive),
        .rowScan(rowScan), .hRetraceOut(hRetraceOut), .vBlankOut(vBlankOut),
        .displayEnableOut(displayEnableOut), .lineCount(lineCount), .memAddr(memAddr));
    crt_far_side_model partner(.clock(clock), .reset(reset), .hSync(hRetraceOut), .syncCount(syncCount));

    initial
    begin
        forever #2 clock = ~clock;
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wrReg(input logic [7:0] idx, input logic [7:0] data);
        @(posedge clock);
        regIndex <= idx;
        regWrData <= data;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wrReg

    task automatic rdReg(input logic [7:0] idx, input logic [7:0] exp);
        @(posedge clock);
        regIndex <= idx;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        @(negedge clock);
        chk(16'(regRdData), 16'(exp), "register read");
    endtask : rdReg

    task automatic pulse();
        @(posedge clock);
        hRetrace <= 1'b1;
        @(posedge clock);
        hRetrace <= 1'b0;
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask : pulse

    task automatic goLine(input int n);
        int k;
        k = 0;
        @(negedge clock);
        while (lineCount !== 10'(n) && k < 1100)
        begin
            pulse();
            k++;
        end
        chk(16'(lineCount), 16'(n), "line reached");
    endtask : goLine

    // disabling first forces the line count and the halving phase to zero
    task automatic restart(input logic [7:0] m);
        wrReg(IDX_CRT_MODE_CONTROL, 8'h00);
        wrReg(IDX_CRT_MODE_CONTROL, m);
    endtask : restart

    // a wrap to line zero loads the start address
    task automatic reload();
        @(posedge clock);
        verticalTotal <= 10'h003;
        goLine(1);
        goLine(0);
    endtask : reload

    task automatic countRun(input logic [7:0] m, input logic [15:0] exp);
        reload();
        wrReg(IDX_CRT_MODE_CONTROL, m);
        @(posedge clock);
        displayActive <= 1'b1;
        repeat (10) @(posedge clock);
        displayActive <= 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk(memAddr, exp, "address count");
    endtask : countRun

    function automatic logic [15:0] shape(input logic [15:0] c, input logic [7:0] m, input logic [4:0] rs);
        logic [15:0] a;
        a = m[6] ? c : {c[14:0], m[5] ? c[15] : c[13]};
        if (!m[1])
            a[14] = rs[1];
        if (!m[0])
            a[13] = rs[0];
        return a;
    endfunction : shape

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic test_regs();
        logic [7:0] idx[5];
        logic [7:0] back[5];
        idx = '{IDX_VBLANK_START_LOW, IDX_VBLANK_END, IDX_CRT_MODE_CONTROL, IDX_SPLIT_LINE_COMPARE_LOW, 8'h14};
        back = '{8'hFF, MASK_BLANK_END_VALUE, MASK_MODE_CONTROL, 8'hFF, 8'h00};
        for (int i = 0; i < 5; i++)
        begin
            rdReg(idx[i], 8'h00);
            wrReg(idx[i], 8'hFF);
            rdReg(idx[i], back[i]);
        end
        $display("test registers done");
    endtask : test_regs

    task automatic test_enable();
        int base;
        @(posedge clock);
        displayActive <= 1'b1;
        restart(8'h00);
        base = syncCount;
        repeat (3) pulse();
        chk(16'(lineCount), 16'h0000, "line while disabled");
        chk(16'(syncCount - base), 16'h0000, "sync while disabled");
        chk(16'(displayEnableOut), 16'h0000, "display enable while disabled");
        wrReg(IDX_CRT_MODE_CONTROL, 8'h80);
        base = syncCount;
        repeat (5) pulse();
        chk(16'(lineCount), 16'h0005, "line per retrace");
        chk(16'(syncCount - base), 16'h0005, "sync while enabled");
        chk(16'(displayEnableOut), 16'h0001, "display enable while enabled");
        @(posedge clock);
        verticalTotal <= 10'h006;
        repeat (2) pulse();
        chk(16'(lineCount), 16'h0000, "wrap after total");
        restart(8'h84);
        repeat (6) pulse();
        chk(16'(lineCount), 16'h0003, "line per two retraces");
        @(posedge clock);
        displayActive <= 1'b0;
        $display("test enable done");
    endtask : test_enable

    task automatic test_blank();
        @(posedge clock);
        overflowReg <= 8'h18;
        maxScanLineReg <= 8'h40;
        verticalTotal <= 10'h3FF;
        wrReg(IDX_VBLANK_START_LOW, 8'h05);
        wrReg(IDX_VBLANK_END, 8'h10);
        restart(8'hC3);
        goLine(5);
        chk(16'(vBlankOut), 16'h0000, "no blank at low byte only");
        goLine(261);
        chk(16'(vBlankOut), 16'h0001, "blank start");
        goLine(271);
        chk(16'(vBlankOut), 16'h0001, "blank held");
        goLine(272);
        chk(16'(vBlankOut), 16'h0000, "blank end on seven bits");
        $display("test blank done");
    endtask : test_blank

    task automatic test_addr();
        logic [7:0] m;
        wrReg(IDX_SPLIT_LINE_COMPARE_LOW, 8'hFF);
        reload();
        for (logic [4:0] k = 5'h00; k < 5'h10; k++)
        begin
            m = {1'b1, k[3], k[2], 3'b000, k[1], k[0]};
            @(posedge clock);
            rowScan <= k ^ 5'h02;
            wrReg(IDX_CRT_MODE_CONTROL, m);
            repeat (2) @(posedge clock);
            @(negedge clock);
            chk(memAddr, shape(START, m, k ^ 5'h02), "shaped address");
        end
        countRun(8'hC3, START + 16'h000A);
        countRun(8'hCB, START + 16'h0005);
        $display("test address done");
    endtask : test_addr

    task automatic test_split();
        reload();
        wrReg(IDX_SPLIT_LINE_COMPARE_LOW, 8'h02);
        @(posedge clock);
        verticalTotal <= 10'h3FF;
        goLine(769);
        chk(memAddr, START, "no clear below target");
        goLine(770);
        chk(memAddr, 16'h0000, "split clears address");
        $display("test split done");
    endtask : test_split

    // ************************************************************
    // run control
    // ************************************************************
    task automatic end_sim();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            num_errors++;
            $display("BAD %0t run took too long", $time);
            end_sim();
        end
    end

    initial
    begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        test_regs();
        test_enable();
        test_blank();
        test_addr();
        test_split();
        end_sim();
    end
endmodule : crt_vertical_timing_addr_ctrl_tb_top
